// ===== hdl/can_id_acceptance_filter.sv
// identifier acceptance filter, config lock, clock select and prescaler
`timescale 1ns/1ps

module can_id_acceptance_filter
  import can_filter_pkg::*;
#(
  parameter int ERR_W = 8  // width of each error counter
) (
  input  wire logic              sys_clk,            // 250 mhz clock
  input  wire logic              rst,                // sync reset, high
  // configuration write port
  input  wire logic              cfg_wr,             // write strobe
  input  wire logic [4:0]        cfg_sel,            // register select
  input  wire logic [7:0]        cfg_wdata,          // write data
  input  wire logic              enable_wr,          // enable write strobe
  input  wire logic              enable_wdata,       // enable write value
  input  wire logic              special_mode,       // enable stays writable
  // mode control
  input  wire logic              init_request,       // init mode request
  input  wire logic              power_down,         // power down mode
  // clock sources
  input  wire logic              osc_tick,           // oscillator clock enable
  // receive side
  input  wire logic              rx_id_valid,        // message received ok
  input  wire logic [31:0]       rx_id_bytes,        // id bytes 0..3, b0 high
  input  wire logic              rx_fifo_room,       // fifo can take a message
  input  wire logic              rx_full_clear,      // software clears full
  input  wire logic              rx_err_inc,         // protocol bumps rx errors
  input  wire logic              tx_err_inc,         // protocol bumps tx errors
  input  wire logic              tx_core,            // protocol transmit bit
  // outputs
  output logic                   init_acknowledge,   // init mode entered
  output logic                   module_enable_once, // module enable bit
  output logic                   tx_pin,             // can transmit pin
  output logic                   rx_full_flag,       // foreground buffer full
  output logic [HIT_W-1:0]       filter_hit_index,   // lowest hit filter
  output logic                   rx_accept,          // shift into fifo, pulse
  output logic                   tq_tick,            // time quantum, pulse
  output logic [7:0]             control_reg_one,    // control 1 value
  output logic [7:0]             bit_timing_reg_zero,// timing 0 value
  output logic [7:0]             bit_timing_reg_one, // timing 1 value
  output logic [7:0]             acceptance_control_reg, // mode and hit
  output logic [ERR_W-1:0]       rx_err_count,       // receive errors
  output logic [ERR_W-1:0]       tx_err_count        // transmit errors
);

  // whole register state of the block
  typedef struct packed {
    init_state_t                     ist;       // init handshake state
    logic                            en;        // module enable
    logic                            en_done;   // first enable write taken
    logic [7:0]                      ctl1;      // control 1
    logic [7:0]                      btr0;      // bit timing 0
    logic [7:0]                      btr1;      // bit timing 1
    logic [IDAM_W-1:0]               idam;      // filter mode
    logic [HIT_W-1:0]                hit;       // last hit index
    logic [NUM_BYTES-1:0][BYTE_W-1:0] acc;      // acceptance bytes
    logic [NUM_BYTES-1:0][BYTE_W-1:0] msk;      // mask bytes
    logic                            full;      // rx full flag
    logic                            accept;    // accept pulse
    logic [BRP_W-1:0]                pre;       // prescaler count
    logic                            tq;        // quantum pulse
    logic                            tx;        // registered tx pin
    logic [ERR_W-1:0]                rxerr;     // receive error count
    logic [ERR_W-1:0]                txerr;     // transmit error count
  } state_t;

  state_t st;       // registered state
  state_t next_st;  // next state

  // per-filter hit vectors for each width
  logic [1:0] hit32;  // two 32-bit filters
  logic [3:0] hit16;  // four 16-bit filters
  logic [7:0] hit8;   // eight 8-bit filters
  logic [7:0] hits;   // hits of the active mode
  logic [HIT_W-1:0] low_hit;  // index of the lowest hit
  logic       any_hit;        // at least one filter matched
  logic       cfg_open;       // config writes allowed
  logic       core_tick;      // can core clock enable
  logic [2:0] sel_idx;        // byte index inside a group

  // a filter section hits when every compared bit agrees
  function automatic logic match(input logic [31:0] id,
                                 input logic [31:0] acc,
                                 input logic [31:0] msk,
                                 input logic [31:0] used);
    // mask 1 drops the bit, so acc under a set mask is never seen
    match = (((id ^ acc) & ~msk & used) == 32'h0000_0000);
  endfunction

  // hit computation for all three widths in parallel
  always_comb begin
    // bank bytes line up with the identifier bytes 0..3
    for (int b = 0; b < 2; b++) begin
      // full identifier plus rtr, ide and srr per bank
      hit32[b] = match(rx_id_bytes,
                       {st.acc[4*b], st.acc[4*b+1],
                        st.acc[4*b+2], st.acc[4*b+3]},
                       {st.msk[4*b], st.msk[4*b+1],
                        st.msk[4*b+2], st.msk[4*b+3]},
                       32'hffff_ffff);
    end
    for (int f = 0; f < 4; f++) begin
      // id bytes 0 and 1 against a byte pair of one bank
      hit16[f] = match({rx_id_bytes[31:16], 16'h0000},
                       {st.acc[2*f], st.acc[2*f+1], 16'h0000},
                       {st.msk[2*f], st.msk[2*f+1], 16'h0000},
                       32'hffff_0000);
    end
    for (int f = 0; f < 8; f++) begin
      // first identifier byte against each single byte
      hit8[f] = match({rx_id_bytes[31:24], 24'h000000},
                      {st.acc[f], 24'h000000},
                      {st.msk[f], 24'h000000},
                      32'hff00_0000);
    end
  end

  // select the hit vector of the active mode
  always_comb begin
    case (filter_mode_t'(st.idam))
      MODE_32:  hits = {6'h00, hit32};
      MODE_16:  hits = {4'h0, hit16};
      MODE_8:   hits = hit8;
      MODE_CLS: hits = 8'h00;             // closed: nothing matches
      default:  hits = 8'h00;
    endcase
  end

  // priority encode, lowest index wins
  // scanning downward lets the lowest matching filter overwrite the rest
  always_comb begin
    low_hit = HIT_RST;
    for (int i = NUM_BYTES - 1; i >= 0; i--) begin
      if (hits[i]) begin
        low_hit = HIT_W'(i);
      end
    end
    any_hit = |hits;  // any single filter suffices
  end

  // config lock and core clock source
  // a write in the edge where the acknowledge rises is still refused
  always_comb begin
    // writes only with request and acknowledge both set
    cfg_open  = init_request && (st.ist == ST_INIT);
    // bus clock is every cycle, oscillator comes as an enable
    core_tick = st.ctl1[CTL1_CLOCK_SOURCE_SELECT_BIT] ? 1'b1 : osc_tick;
    sel_idx   = cfg_sel[2:0] & SEL_IDX_MSK;
  end

  // next state of everything
  always_comb begin
    next_st        = st;
    next_st.accept = 1'b0;
    next_st.tq     = 1'b0;

    // init handshake: acknowledge two cycles after the request
    case (st.ist)
      ST_RUN: begin
        if (init_request) begin
          next_st.ist = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // request dropped before the acknowledge: back on line
        next_st.ist = init_request ? ST_INIT : ST_RUN;
      end
      ST_INIT: begin
        if (!init_request) begin
          next_st.ist = ST_RUN;
        end
      end
      default: next_st.ist = ST_RUN;
    endcase

    // locked configuration writes
    if (cfg_wr && cfg_open) begin
      if ((cfg_sel & SEL_GRP_MSK) == SEL_ACC0) begin
        next_st.acc[sel_idx] = cfg_wdata;
      end else if ((cfg_sel & SEL_GRP_MSK) == SEL_MASK0) begin
        next_st.msk[sel_idx] = cfg_wdata;
      end else begin
        case (cfg_sel)
          SEL_CTL1: next_st.ctl1 = cfg_wdata;
          SEL_BTR0: next_st.btr0 = cfg_wdata;
          SEL_BTR1: next_st.btr1 = cfg_wdata;
          // hit bits are read only, only the mode field lands
          SEL_IDAC: next_st.idam = cfg_wdata[IDAM_LSB +: IDAM_W];
          // error counter selects fall through untouched
          default:  next_st.idam = st.idam;
        endcase
      end
    end

    // error counters move only from the protocol side
    // they wrap at full scale; the protocol side owns the limits
    if (rx_err_inc) begin
      next_st.rxerr = st.rxerr + ERR_W'(1);
    end
    if (tx_err_inc) begin
      next_st.txerr = st.txerr + ERR_W'(1);
    end

    // module enable: one write in normal modes, free in special
    if (enable_wr && (!st.en_done || special_mode)) begin
      next_st.en      = enable_wdata;
      next_st.en_done = 1'b1;
    end

    // prescaler runs on the core clock enable
    // a divider written below the running count restarts it at once
    if (core_tick) begin
      if (st.pre >= st.btr0[BRP_LSB +: BRP_W]) begin
        next_st.pre = PRE_RST;
        next_st.tq  = st.en;  // no quanta while disabled
      end else begin
        next_st.pre = st.pre + BRP_W'(1);
      end
    end

    // end of a valid reception: background buffer was filtered as it
    // filled, only a hit may move on to the fifo
    if (rx_id_valid && any_hit && rx_fifo_room && st.en) begin
      next_st.accept = 1'b1;
      next_st.hit    = low_hit;
    end

    // full flag: software clear loses against a new accept
    if (rx_full_clear) begin
      next_st.full = 1'b0;
    end
    if (rx_id_valid && any_hit && rx_fifo_room && st.en) begin
      next_st.full = 1'b1;
    end

    // recessive at once in init, power down or while disabled, else protocol bit
    next_st.tx = tx_core;
  end

  // state register
  // the struct is cleared first, then each named field gets its reset value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st       <= '0;
      st.ist   <= ST_RUN;
      st.ctl1  <= CTL1_RST;
      st.btr0  <= BYTE_RST;
      st.btr1  <= BYTE_RST;
      st.idam  <= MODE_32;
      st.hit   <= HIT_RST;
      st.pre   <= PRE_RST;
      st.rxerr <= ERR_RST;
      st.txerr <= ERR_RST;
      st.tx    <= RECESSIVE;
    end else begin
      st <= next_st;
    end
  end

  // outputs; the pin override is combinational so that it acts in the
  // same cycle as the mode change, the price is a gate after the flop
  always_comb begin
    init_acknowledge       = (st.ist == ST_INIT);
    module_enable_once     = st.en;
    tx_pin                 = (power_down || init_request || !st.en)
                             ? RECESSIVE : st.tx;
    rx_full_flag           = st.full;
    filter_hit_index       = st.hit;
    rx_accept              = st.accept;
    tq_tick                = st.tq;
    control_reg_one        = st.ctl1;
    bit_timing_reg_zero    = st.btr0;
    bit_timing_reg_one     = st.btr1;
    acceptance_control_reg = {2'h0, st.idam, 1'b0, st.hit}
                             & 8'hff | (8'h00 & IDAC_WR_MASK);
    rx_err_count           = st.rxerr;
    tx_err_count           = st.txerr;
  end

endmodule

// ===== include/can_filter_pkg.sv
// package of constants and types for the can identifier acceptance filter
package can_filter_pkg;

  // width of one configuration byte and of the hit index
  localparam int BYTE_W     = 8;
  localparam int HIT_W      = 3;
  localparam int NUM_BYTES  = 8;   // bytes in both acceptance banks
  localparam int BANK_BYTES = 4;   // bytes in one bank

  // register select codes on the configuration write port
  localparam logic [4:0] SEL_CTL1    = 5'h00; // control_reg_one
  localparam logic [4:0] SEL_BTR0    = 5'h01; // bit_timing_reg_zero
  localparam logic [4:0] SEL_BTR1    = 5'h02; // bit_timing_reg_one
  localparam logic [4:0] SEL_IDAC    = 5'h03; // acceptance_control_reg
  localparam logic [4:0] SEL_RXERR   = 5'h04; // receive error counter
  localparam logic [4:0] SEL_TXERR   = 5'h05; // transmit error counter
  localparam logic [4:0] SEL_ACC0    = 5'h08; // id_accept_regs 0..7
  localparam logic [4:0] SEL_MASK0   = 5'h10; // id_mask_regs 0..7
  localparam logic [4:0] SEL_GRP_MSK = 5'h18; // picks the group bits
  localparam logic [2:0] SEL_IDX_MSK = 3'h7;  // picks the byte index

  // control_reg_one field positions
  localparam int CTL1_CLOCK_SOURCE_SELECT_BIT = 6;  // 1 = bus clock, 0 = oscillator
  // bit_timing_reg_zero prescaler field
  localparam int BRP_LSB = 0;
  localparam int BRP_W   = 6;
  // acceptance_control_reg fields
  localparam int IDAM_LSB = 4;
  localparam int IDAM_W   = 2;
  localparam logic [7:0] IDAC_WR_MASK = 8'h30; // only the mode is writable

  // filter width modes
  typedef enum logic [1:0] {
    MODE_32  = 2'h0, // two 32-bit filters
    MODE_16  = 2'h1, // four 16-bit filters
    MODE_8   = 2'h2, // eight 8-bit filters
    MODE_CLS = 2'h3  // filter closed
  } filter_mode_t;

  // reset values
  localparam logic [7:0] CTL1_RST = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ERR_RST  = 8'h00;
  localparam logic [2:0] HIT_RST  = 3'h0;
  localparam logic [5:0] PRE_RST  = 6'h00;

  // pin levels
  localparam logic RECESSIVE = 1'b1;

  // init handshake states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001, // on line
    ST_ENTER = 3'b010, // request seen, acknowledge pending
    ST_INIT  = 3'b100  // initialization mode, config unlocked
  } init_state_t;

endpackage

// ===== bench/can_filter_properties.sv
// checker of port timing for the identifier acceptance filter
`timescale 1ns/1ps
module can_filter_properties
  import can_filter_pkg::*;
#(
  parameter int ERR_W = 8  // error counter width
) (
  input wire logic             sys_clk,                // clock
  input wire logic             rst,                    // sync reset
  input wire logic             cfg_wr,                 // write strobe
  input wire logic [4:0]       cfg_sel,                // register select
  input wire logic             init_request,           // init request
  input wire logic             power_down,             // power down
  input wire logic             enable_wr,              // enable write
  input wire logic             rx_id_valid,            // message valid
  input wire logic             rx_fifo_room,           // fifo room
  input wire logic             rx_err_inc,             // rx error bump
  input wire logic             init_acknowledge,       // init entered
  input wire logic             module_enable_once,     // enable bit
  input wire logic             tx_pin,                 // transmit pin
  input wire logic             rx_full_flag,           // buffer full
  input wire logic [HIT_W-1:0] filter_hit_index,       // hit index
  input wire logic             rx_accept,              // accept pulse
  input wire logic             tq_tick,                // quantum pulse
  input wire logic [7:0]       bit_timing_reg_zero,    // timing 0
  input wire logic [7:0]       acceptance_control_reg, // mode and hit
  input wire logic [ERR_W-1:0] rx_err_count            // rx errors
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // filter mode field of the acceptance control value
  wire logic [1:0] mode = acceptance_control_reg[5:4];

  property p_tx_rec;
    (power_down || init_request) |-> tx_pin;
  endproperty
  a_tx_rec: assert property (p_tx_rec)
    else $error("transmit pin not recessive");
  property p_init_ack;
    init_request [*3] |-> init_acknowledge;
  endproperty
  a_init_ack: assert property (p_init_ack)
    else $error("init acknowledge late");
  // the timing register may only move after an unlocked write
  property p_lock;
    $changed(bit_timing_reg_zero) |-> $past(cfg_wr && init_request
      && init_acknowledge && cfg_sel == SEL_BTR0);
  endproperty
  a_lock: assert property (p_lock)
    else $error("timing register changed while locked");
  property p_err;
    !rx_err_inc |=> $stable(rx_err_count);
  endproperty
  a_err: assert property (p_err)
    else $error("error counter moved without protocol event");
  property p_full;
    rx_accept |-> rx_full_flag
      && acceptance_control_reg[2:0] == filter_hit_index;
  endproperty
  a_full: assert property (p_full)
    else $error("accept without full flag or hit bits");
  property p_cause;
    rx_accept |-> $past(rx_id_valid && rx_fifo_room && module_enable_once);
  endproperty
  a_cause: assert property (p_cause)
    else $error("accept without a received message");
  property p_rise;
    $rose(rx_full_flag) |-> rx_accept;
  endproperty
  a_rise: assert property (p_rise)
    else $error("full flag set without acceptance");
  property p_closed;
    $past(mode) == MODE_CLS |-> !rx_accept;
  endproperty
  a_closed: assert property (p_closed)
    else $error("closed filter accepted a message");
  property p_range32;
    $past(mode) == MODE_32 && rx_accept |-> filter_hit_index < 3'h2;
  endproperty
  a_range32: assert property (p_range32)
    else $error("hit index out of range in wide mode");
  property p_range16;
    $past(mode) == MODE_16 && rx_accept |-> filter_hit_index < 3'h4;
  endproperty
  a_range16: assert property (p_range16)
    else $error("hit index out of range in half mode");
  property p_once;
    $changed(module_enable_once) |-> $past(enable_wr);
  endproperty
  a_once: assert property (p_once)
    else $error("enable bit moved without a write");
  c_hit7: cover property (rx_accept && filter_hit_index == 3'h7);
  c_init: cover property ($rose(init_acknowledge));
  c_tq: cover property (tq_tick);
endmodule
bind can_id_acceptance_filter can_filter_properties #(.ERR_W(ERR_W)) u_props (
  .sys_clk, .rst, .cfg_wr, .cfg_sel, .init_request, .power_down,
  .enable_wr, .rx_id_valid, .rx_fifo_room, .rx_err_inc,
  .init_acknowledge, .module_enable_once, .tx_pin, .rx_full_flag,
  .filter_hit_index, .rx_accept, .tq_tick, .bit_timing_reg_zero,
  .acceptance_control_reg, .rx_err_count);

// ===== bench/can_remote_node.sv
// far-side node model: hands received identifiers to the filter
`timescale 1ns/1ps
module can_remote_node (
  input  wire logic        sys_clk,     // clock
  input  wire logic        send,        // bench asks for a frame
  input  wire logic [31:0] id,          // identifier bytes to send
  output logic             rx_id_valid, // frame received ok
  output logic [31:0]      rx_id_bytes  // identifier bytes
);
  initial rx_id_valid = 1'b0;
  initial rx_id_bytes = 32'h0;
  // one frame per request, valid for one cycle
  // stale bytes are inverted each idle cycle, so an old id comes back every other cycle
  always @(posedge sys_clk) begin
    rx_id_valid <= send;
    rx_id_bytes <= send ? id : ~rx_id_bytes;
  end
endmodule

// ===== bench/can_id_acceptance_filter_tb_top.sv
// self-checking bench for the identifier acceptance filter
`timescale 1ns/1ps
module can_id_acceptance_filter_tb_top
  import can_filter_pkg::*;
;
  logic sys_clk, rst, cfg_wr, enable_wr, enable_wdata, special_mode;
  logic init_request, power_down, rx_id_valid, rx_fifo_room;
  logic osc_tick = 1'b0;         // oscillator enable, one driver only
  logic rx_full_clear, rx_err_inc, tx_err_inc, tx_core, send;
  logic init_acknowledge, module_enable_once, tx_pin, rx_full_flag;
  logic rx_accept, tq_tick;
  logic [4:0]  cfg_sel;
  logic [7:0]  cfg_wdata, control_reg_one, acceptance_control_reg;
  logic [7:0]  bit_timing_reg_zero, bit_timing_reg_one;
  logic [7:0]  rx_err_count, tx_err_count;
  logic [2:0]  filter_hit_index;
  logic [31:0] id, rx_id_bytes, nid, pid;
  logic [63:0] acc, msk, a, k;   // filter bytes, byte 0 on top
  logic [3:0]  e;
  logic        xf;               // expected full flag
  logic [2:0]  q[$];             // expected hit of each accept
  int n_fail, compares, seed, w, f;

  can_id_acceptance_filter dut (.sys_clk, .rst, .cfg_wr, .cfg_sel,
    .cfg_wdata, .enable_wr, .enable_wdata, .special_mode, .init_request,
    .power_down, .osc_tick, .rx_id_valid, .rx_id_bytes, .rx_fifo_room,
    .rx_full_clear, .rx_err_inc, .tx_err_inc, .tx_core, .init_acknowledge,
    .module_enable_once, .tx_pin, .rx_full_flag, .filter_hit_index,
    .rx_accept, .tq_tick, .control_reg_one, .bit_timing_reg_zero,
    .bit_timing_reg_one, .acceptance_control_reg, .rx_err_count,
    .tx_err_count);
  can_remote_node u_node (.sys_clk, .send, .id, .rx_id_valid,
    .rx_id_bytes);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // oscillator enable every other cycle, slower than the bus clock
  always @(negedge sys_clk) osc_tick <= ~osc_tick;

  task automatic chk_bit(string nm, logic ex, logic got);
    compares++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, ex, got);
    end
  endtask
  task automatic chk_val(string nm, logic [7:0] ex, logic [7:0] got);
    compares++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // strobe stays high across back-to-back writes; caller drops it
  task automatic cfg(logic [4:0] s, logic [7:0] d);
    cfg_sel = s;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
  endtask
  // cycles between two quantum pulses
  task automatic tq_gap(int ex);
    int c;
    c = 0;
    while (tq_tick !== 1'b1 && c < 99) begin
      @(negedge sys_clk);
      c++;
    end
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (tq_tick !== 1'b1 && c < 99);
    chk_val("tq_gap", 8'(ex), 8'(c));
  endtask
  // lowest matching filter, bit 3 set when any filter hits
  function automatic logic [3:0] ref_hit(logic [1:0] m, logic [31:0] d);
    logic [63:0] tm, t;
    int wd;
    ref_hit = 4'h0;
    wd = 32 >> m;
    tm = ~64'h0 << (64 - wd);
    for (int i = 7; i >= 0; i--) begin
      t = ((acc << (wd * i)) ^ {d, 32'h0}) & ~(msk << (wd * i)) & tm;
      if (m != 2'h3 && i < (2 << m) && t == 64'h0)
        ref_hit = {1'b1, 3'(i)};
    end
  endfunction

  // results: each accept takes the oldest expected hit
  always @(negedge sys_clk) begin
    if (rx_accept === 1'b1) begin
      if (q.size() == 0)
        chk_bit("accept", 1'b0, 1'b1);
      else
        chk_val("hit", 8'(q.pop_front()), 8'(filter_hit_index));
      chk_bit("full", 1'b1, rx_full_flag);
    end
  end

  initial begin
    repeat (5000) @(negedge sys_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    {cfg_wr, enable_wr, enable_wdata, special_mode, init_request} = '0;
    {power_down, rx_full_clear, rx_err_inc, tx_err_inc} = '0;
    {tx_core, send, cfg_sel, cfg_wdata, id, pid} = '0;
    rx_fifo_room = 1'b1;
    seed = 62298;
    xf = 1'b0;
    rst = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    chk_val("ctl1", CTL1_RST, control_reg_one);
    chk_bit("tx_pin", 1'b1, tx_pin);
    // locked write, two enable writes and one protocol error bump
    cfg(SEL_BTR0, 8'h03);
    cfg_wr = 1'b0;
    {enable_wr, enable_wdata, rx_err_inc} = 3'b111;
    @(negedge sys_clk);
    {enable_wdata, rx_err_inc} = 2'b00;
    @(negedge sys_clk);
    enable_wr = 1'b0;
    @(negedge sys_clk);
    chk_bit("enable", 1'b1, module_enable_once);
    chk_val("btr0", 8'h00, bit_timing_reg_zero);
    for (int m = 0; m < 4; m++) begin
      acc = {$random(seed), $random(seed)};
      msk = {$random(seed), $random(seed)} | {$random(seed), $random(seed)};
      init_request = 1'b1;
      #1 chk_bit("tx_pin", 1'b1, tx_pin);
      repeat (3) @(negedge sys_clk);
      chk_bit("init_ack", 1'b1, init_acknowledge);
      for (int i = 0; i < 8; i++) begin
        cfg(SEL_ACC0 | 5'(i), acc[63-8*i -: 8]);
        cfg(SEL_MASK0 | 5'(i), msk[63-8*i -: 8]);
      end
      cfg(SEL_IDAC, 8'hcf | 8'(m << 4));
      cfg(SEL_CTL1, m[0] ? 8'h01 : 8'h41);
      cfg(SEL_BTR0, 8'(m + 1));
      cfg(SEL_RXERR, 8'h5a);
      cfg(SEL_BTR1, 8'(m * 7 + 2));
      cfg(SEL_TXERR, 8'ha5);
      cfg_wr = 1'b0;
      init_request = 1'b0;
      @(negedge sys_clk);
      chk_bit("init_ack", 1'b0, init_acknowledge);
      chk_val("idac", 8'(m << 4), acceptance_control_reg & 8'hf8);
      chk_val("rx_err", 8'h01, rx_err_count);
      chk_val("tx_err", 8'h00, tx_err_count);
      chk_val("btr1", 8'(m * 7 + 2), bit_timing_reg_one);
      chk_val("ctl1", m[0] ? 8'h01 : 8'h41, control_reg_one);
      // back-to-back frames; room of frame j is set one cycle later
      w = 32 >> m;
      for (int j = 0; j <= 40; j++) begin
        chk_bit("full", xf, rx_full_flag);
        rx_fifo_room = ($random(seed) & 7) != 0;
        rx_full_clear = 1'($random(seed));
        e = ref_hit(2'(m), pid);
        if (j > 0 && e[3] && rx_fifo_room)
          q.push_back(e[2:0]);
        // set wins over a clear in the same cycle
        xf = (j > 0 && e[3] && rx_fifo_room) || (xf && !rx_full_clear);
        chk_bit("tx_pin", tx_core, tx_pin);
        tx_core = j < 40 ? 1'($random(seed)) : 1'b0;
        // aim at one filter, then sometimes flip a random bit
        f = ($random(seed) & 7) % (2 << m);
        a = acc << (w * f);
        k = (msk << (w * f)) | ~(~64'h0 << (64 - w));
        nid = a[63:32] ^ ($random(seed) & k[63:32]);
        if ($random(seed) & 1)
          nid = nid ^ (32'h1 << ($random(seed) & 31));
        send = j < 40;
        id = nid;
        pid = nid;
        @(negedge sys_clk);
      end
      // a standing clear would wipe the last accept the model expects
      rx_full_clear = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk_val("pending", 8'h00, 8'(q.size()));
      tq_gap((m + 2) * (m[0] ? 2 : 1));
    end
    power_down = 1'b1;
    #1 chk_bit("tx_pin", 1'b1, tx_pin);
    @(negedge sys_clk);
    // special mode lets the enable bit be written again
    {special_mode, enable_wr, enable_wdata} = 3'b110;
    @(negedge sys_clk);
    {special_mode, enable_wr} = 2'b00;
    @(negedge sys_clk);
    chk_bit("enable", 1'b0, module_enable_once);
    finish_test();
  end
endmodule
